/* File: core/sts_defines.vh */
// Constants for the supply and thermal supervisor
`ifndef STS_DEFINES_VH
`define STS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STS_REG_STATUS 4'h0
`define STS_REG_CLEAR 4'h1
`define STS_REG_CTRL 4'h2
`define STS_REG_MODE 4'h3
`define STS_REG_MODE_REQ 4'h4

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define STS_F_POR 0
`define STS_F_BATTERY_UNDERVOLTAGE_FLAG 1
`define STS_F_BATTERY_OVERVOLTAGE_FLAG 2
`define STS_F_WARN 3
`define STS_F_MAIN_UV 4
`define STS_F_MAIN_OV 5
`define STS_F_SHORT 6
`define STS_F_SEC_UV 7
`define STS_F_XCVR_UV 8
`define STS_F_TSD 9
`define STS_F_SEC_OT 10
`define STS_F_TPW 11
`define STS_F_FAILURE 12
`define STS_NFLAGS 13

// ----------------------------------------
// Control bit positions and reset values
// ----------------------------------------
`define STS_C_WAKE_WD 0
`define STS_C_HYS 1
`define STS_C_OV_RST 2
`define STS_C_SEC_ON 4
`define STS_CTRL_RST 8'h01

// ----------------------------------------
// Modes
// ----------------------------------------
`define STS_M_INIT 3'h0
`define STS_M_NORMAL 3'h1
`define STS_M_STOP 3'h2
`define STS_M_SLEEP 3'h3
`define STS_M_RESTART 3'h4
`define STS_M_FAILSAFE 3'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define STS_CLK_MHZ 200
`define STS_SC_TIME_MS 2
`define STS_SC_CYCLES (`STS_SC_TIME_MS * 1000 * `STS_CLK_MHZ)
`define STS_RD_TIME_US 10
`define STS_RD_CYCLES (`STS_RD_TIME_US * `STS_CLK_MHZ)
`define STS_SEC_BLANK_US 100
`define STS_SEC_BLANK_CYCLES (`STS_SEC_BLANK_US * `STS_CLK_MHZ)

`endif

/* File: core/sts_sync.v */
// Two-stage synchroniser bank for monitor inputs
`default_nettype none

module sts_sync #(
  parameter W = 16
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta;

  // ----------------------------------------
  // Double flop; first stage read only here
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

`default_nettype wire

/* File: core/sts_supervisor.v */
// Supply and thermal supervisor core
`include "sts_defines.vh"
`default_nettype none

module sts_supervisor #(
  parameter SC_CYCLES = `STS_SC_CYCLES,
  parameter BLANK_CYCLES = `STS_SEC_BLANK_CYCLES
) (
  input wire core_clk_i,
  input wire srst_i,
  // Filtered analog monitors (asynchronous)
  input wire vs_por_ok_i,
  input wire battery_undervoltage_flag_i,
  input wire battery_overvoltage_flag_i,
  input wire main_warn_i,
  input wire main_below_rst_i,
  input wire main_below_rt1_i,
  input wire main_ov_i,
  input wire sec_uv_i,
  input wire xcvr_uv_i,
  input wire sec_tsd_i,
  input wire xcvr_tsd_i,
  input wire tpw_i,
  input wire bus_wake_i,
  input wire load_above_peak_i,
  input wire charge_pump_en_i,
  input wire config_strap_state_i,
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // Outputs
  output reg reset_out_n_o,
  output reg fail_output_o,
  output reg main_reg_en_o,
  output reg sec_reg_en_o,
  output reg xcvr_tx_en_o,
  output reg [1:0] xcvr_fail_o,
  output reg wake_irq_o,
  output reg rx_low_o,
  output reg wd_long_window_start_o,
  output reg [2:0] mode_o
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  wire [15:0] s;
  sts_sync #(.W(16)) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({config_strap_state_i, charge_pump_en_i, load_above_peak_i, bus_wake_i,
      tpw_i, xcvr_tsd_i, sec_tsd_i, xcvr_uv_i, sec_uv_i, main_ov_i, main_below_rt1_i,
      main_below_rst_i, main_warn_i, battery_overvoltage_flag_i, battery_undervoltage_flag_i, vs_por_ok_i}),
    .sync_o(s)
  );

  wire por_ok = s[0];
  wire battery_undervoltage_flag = s[1];
  wire battery_overvoltage_flag = s[2];
  wire warn = s[3];
  wire below_rst = s[4];
  wire below_rt1 = s[5];
  wire m_ov = s[6];
  wire sec_uv = s[7];
  wire x_uv = s[8];
  wire sec_tsd = s[9];
  wire x_tsd = s[10];
  wire temperature_prewarning_flag = s[11];
  wire wake = s[12];
  wire peak = s[13];
  wire pump = s[14];
  wire strap = s[15];

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [2:0] mode;
  reg [`STS_NFLAGS-1:0] flags;
  reg [7:0] ctrl;
  reg [27:0] sc_cnt;
  reg [15:0] rd_cnt;
  reg [15:0] blank_cnt;
  reg uv_pending;
  reg ov_restart;
  reg ov_pump_latch;
  reg por_seen;
  reg wake_d;
  reg sec_on_d;
  // Reset delay reload, cut to the counter width on purpose
  localparam [31:0] RD_FULL = `STS_RD_CYCLES;

  // Saturating timer helper
  function [27:0] sts_inc;
    input [27:0] v;
    begin
      sts_inc = (&v) ? v : v + 28'h0000001;
    end
  endfunction

  wire run = por_ok & por_seen;
  wire clr_wr = reg_wr_i && (reg_addr_i == `STS_REG_CLEAR);
  wire ctrl_wr = reg_wr_i && (reg_addr_i == `STS_REG_CTRL);
  wire mode_wr = reg_wr_i && (reg_addr_i == `STS_REG_MODE_REQ);
  wire in_active = (mode == `STS_M_INIT) || (mode == `STS_M_RESTART) ||
    (mode == `STS_M_NORMAL);
  wire stop_mon = (mode == `STS_M_STOP) && (peak || warn);
  wire uv_mon = in_active || stop_mon;
  wire ov_mon = in_active || stop_mon || pump;
  // Release point raised when hysteresis bit is set
  wire main_low = ctrl[`STS_C_HYS] ? below_rt1 : below_rst;
  wire sc_active = main_reg_en_o && !battery_undervoltage_flag;
  wire sec_blank = (blank_cnt != 16'h0000) || (ctrl[`STS_C_SEC_ON] != sec_on_d);

  // Condition currently present for the battery UV/OV, TSD and TPW flags (clears are refused while true)
  reg [`STS_NFLAGS-1:0] present;
  reg [`STS_NFLAGS-1:0] setv;
  always @* begin
    present = {`STS_NFLAGS{1'b0}};
    present[`STS_F_BATTERY_UNDERVOLTAGE_FLAG] = battery_undervoltage_flag;
    present[`STS_F_BATTERY_OVERVOLTAGE_FLAG] = battery_overvoltage_flag && !ov_pump_latch;
    present[`STS_F_TSD] = sec_tsd || x_tsd;
    present[`STS_F_TPW] = temperature_prewarning_flag;
    setv = {`STS_NFLAGS{1'b0}};
    setv[`STS_F_BATTERY_UNDERVOLTAGE_FLAG] = uv_mon && battery_undervoltage_flag;
    setv[`STS_F_BATTERY_OVERVOLTAGE_FLAG] = ov_mon && battery_overvoltage_flag;
    setv[`STS_F_WARN] = main_reg_en_o && warn;
    setv[`STS_F_MAIN_UV] = uv_pending && rd_cnt == 16'h0001 && !main_low;
    setv[`STS_F_MAIN_OV] = main_reg_en_o && m_ov;
    setv[`STS_F_SHORT] = sc_active && sc_cnt >= SC_CYCLES;
    setv[`STS_F_FAILURE] = setv[`STS_F_SHORT];
    setv[`STS_F_SEC_UV] = sec_reg_en_o && sec_uv && !sec_blank;
    setv[`STS_F_XCVR_UV] = x_uv;
    setv[`STS_F_TSD] = (sec_reg_en_o && sec_tsd) || x_tsd;
    setv[`STS_F_SEC_OT] = sec_reg_en_o && sec_tsd;
    setv[`STS_F_TPW] = temperature_prewarning_flag;
  end

  // ----------------------------------------
  // Flags: set wins, clear refused while present
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i || !por_ok) begin
      flags <= {`STS_NFLAGS{1'b0}};
      por_seen <= 1'b0;
      ov_pump_latch <= 1'b0;
    end else begin
      por_seen <= 1'b1;
      // Pump switched off while overvoltage set: hold until software clears
      if (flags[`STS_F_BATTERY_OVERVOLTAGE_FLAG] && !pump && !in_active)
        ov_pump_latch <= 1'b1;
      else if (clr_wr && reg_wdata_i[`STS_F_BATTERY_OVERVOLTAGE_FLAG])
        ov_pump_latch <= 1'b0;
      flags <= (flags & ~(clr_wr ? (reg_wdata_i[`STS_NFLAGS-1:0] & ~present)
        : {`STS_NFLAGS{1'b0}})) | setv;
      if (!por_seen)
        flags[`STS_F_POR] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i || !por_ok) begin
      ctrl <= `STS_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl[`STS_C_HYS] <= reg_wdata_i[`STS_C_HYS];
        ctrl[`STS_C_OV_RST] <= reg_wdata_i[`STS_C_OV_RST];
        ctrl[`STS_C_SEC_ON] <= reg_wdata_i[`STS_C_SEC_ON];
        if (mode == `STS_M_NORMAL)
          ctrl[`STS_C_WAKE_WD] <= reg_wdata_i[`STS_C_WAKE_WD];
      end
      if (main_reg_en_o && m_ov && ctrl[`STS_C_OV_RST])
        ctrl[`STS_C_OV_RST] <= 1'b0;
      if (sec_reg_en_o && sec_tsd)
        ctrl[`STS_C_SEC_ON] <= 1'b0;
    end
  end

  // ----------------------------------------
  // Timers: short filter and secondary blanking
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i || !por_ok) begin
      sc_cnt <= 28'h0000000;
      blank_cnt <= 16'h0000;
      sec_on_d <= 1'b0;
    end else begin
      // Counts from enable or from the fall below threshold
      if (!sc_active || !main_low)
        sc_cnt <= 28'h0000000;
      else
        sc_cnt <= sts_inc(sc_cnt);
      sec_on_d <= ctrl[`STS_C_SEC_ON];
      if (ctrl[`STS_C_SEC_ON] && !sec_on_d)
        blank_cnt <= BLANK_CYCLES[15:0];
      else if (blank_cnt != 16'h0000)
        blank_cnt <= blank_cnt - 16'h0001;
    end
  end

  // ----------------------------------------
  // Mode machine and reset output
  // ----------------------------------------
  reg [2:0] next_mode;
  always @* begin
    next_mode = mode;
    case (mode)
      `STS_M_INIT, `STS_M_NORMAL, `STS_M_STOP, `STS_M_RESTART: begin
        if (mode_wr && mode != `STS_M_RESTART)
          next_mode = reg_wdata_i[2:0];
        if (mode == `STS_M_RESTART && rd_cnt == 16'h0001 && !main_low)
          next_mode = `STS_M_NORMAL;
        if (main_reg_en_o && main_low && mode != `STS_M_INIT)
          next_mode = `STS_M_RESTART;
        if (main_reg_en_o && m_ov && ctrl[`STS_C_OV_RST])
          next_mode = strap ? `STS_M_RESTART : `STS_M_FAILSAFE;
        if (setv[`STS_F_SHORT])
          next_mode = `STS_M_FAILSAFE;
      end
      `STS_M_SLEEP: begin
        if (wake)
          next_mode = `STS_M_RESTART;
      end
      `STS_M_FAILSAFE: begin
        if (wake)
          next_mode = `STS_M_RESTART;
      end
      default: next_mode = `STS_M_INIT;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (srst_i || !run) begin
      mode <= `STS_M_INIT;
      rd_cnt <= RD_FULL[15:0];
      reset_out_n_o <= 1'b0;
      uv_pending <= 1'b0;
      ov_restart <= 1'b0;
      fail_output_o <= 1'b0;
      main_reg_en_o <= 1'b0;
    end else begin
      mode <= next_mode;
      main_reg_en_o <= (next_mode != `STS_M_FAILSAFE) && (next_mode != `STS_M_SLEEP);
      if (next_mode == `STS_M_RESTART && mode != `STS_M_RESTART) begin
        ov_restart <= m_ov && ctrl[`STS_C_OV_RST];
        uv_pending <= !(m_ov && ctrl[`STS_C_OV_RST]);
        rd_cnt <= RD_FULL[15:0];
        reset_out_n_o <= 1'b0;
      end else if (!reset_out_n_o) begin
        // Overvoltage restart runs the delay even if the fault persists
        if (main_low && !ov_restart)
          rd_cnt <= RD_FULL[15:0];
        else if (rd_cnt != 16'h0001)
          rd_cnt <= rd_cnt - 16'h0001;
        else begin
          reset_out_n_o <= 1'b1;
          uv_pending <= 1'b0;
          ov_restart <= 1'b0;
          if (mode == `STS_M_INIT || mode == `STS_M_RESTART)
            mode <= `STS_M_NORMAL;
        end
      end
      if (next_mode == `STS_M_FAILSAFE || next_mode == `STS_M_SLEEP)
        reset_out_n_o <= 1'b0;
      if (next_mode == `STS_M_FAILSAFE)
        fail_output_o <= 1'b1;
      else if (ov_restart || (next_mode == `STS_M_RESTART && m_ov))
        fail_output_o <= 1'b1;
      else if (mode_wr && mode == `STS_M_NORMAL)
        fail_output_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bus wake in Stop and block outputs
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i || !run) begin
      wake_d <= 1'b0;
      wake_irq_o <= 1'b0;
      rx_low_o <= 1'b0;
      wd_long_window_start_o <= 1'b0;
      sec_reg_en_o <= 1'b0;
      xcvr_tx_en_o <= 1'b0;
      xcvr_fail_o <= 2'h0;
      mode_o <= `STS_M_INIT;
    end else begin
      wake_d <= wake;
      // Edge of a synchronised level, so one pulse per wake
      wake_irq_o <= wake && !wake_d && mode == `STS_M_STOP;
      wd_long_window_start_o <= wake && !wake_d && mode == `STS_M_STOP &&
        ctrl[`STS_C_WAKE_WD];
      if (wake && !wake_d && mode == `STS_M_STOP)
        rx_low_o <= 1'b1;
      else if (mode != `STS_M_STOP)
        rx_low_o <= 1'b0;
      sec_reg_en_o <= ctrl[`STS_C_SEC_ON] && !sec_tsd;
      xcvr_tx_en_o <= !x_tsd;
      if (x_tsd)
        xcvr_fail_o <= 2'h1;
      else if (clr_wr && reg_wdata_i[`STS_F_TSD])
        xcvr_fail_o <= 2'h0;
      mode_o <= mode;
    end
  end

  // ----------------------------------------
  // Read port: data one cycle after strobe
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `STS_REG_STATUS: reg_rdata_o <= {{(16-`STS_NFLAGS){1'b0}}, flags};
        `STS_REG_CTRL: reg_rdata_o <= {8'h00, ctrl};
        `STS_REG_MODE: reg_rdata_o <= {13'h0000, mode};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule

`default_nettype wire

/* File: bench/sts_mcu_model.sv */
// Microcontroller model driving the supervisor register port
`include "sts_defines.vh"
`default_nettype none
module sts_mcu_model (
  input wire logic core_clk_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [3:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    reg_addr_o = 4'h0;
    reg_wdata_o = 16'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One-cycle write; data lines inverted once released so stale values never match
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask
  // Overvoltage reset dropped before Stop so noise cannot trip a restart
  task automatic enter_stop(input logic [15:0] ctrl);
    wr(`STS_REG_CTRL, ctrl & ~(16'h1 << `STS_C_OV_RST));
    wr(`STS_REG_MODE_REQ, 16'(`STS_M_STOP));
  endtask
endmodule
`default_nettype wire

/* File: bench/sts_supervisor_monitor.sv */
// Port-level assertions for the supply and thermal supervisor
`include "sts_defines.vh"
`default_nettype none
module sts_supervisor_monitor (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic vs_por_ok_i,
  input wire logic main_below_rst_i,
  input wire logic sec_tsd_i,
  input wire logic xcvr_tsd_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reset_out_n_o,
  input wire logic main_reg_en_o,
  input wire logic sec_reg_en_o,
  input wire logic xcvr_tx_en_o,
  input wire logic wake_irq_o,
  input wire logic rx_low_o,
  input wire logic wd_long_window_start_o,
  input wire logic [2:0] mode_o
);
  localparam int RD_MIN = 2000;
  logic [15:0] low_cnt;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Length of the current low stretch of the reset pin, saturating
  always @(posedge core_clk_i) begin
    if (srst_i || reset_out_n_o) low_cnt <= 16'h0;
    else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h1;
  end
  property p_rd_delay; $rose(reset_out_n_o) |-> low_cnt >= RD_MIN; endproperty
  a_rd_delay: assert property (p_rd_delay) else $error("reset released early");
  property p_rdata_idle; !$past(reg_rd_i) |-> reg_rdata_o == 16'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_irq_pulse; wake_irq_o |=> !wake_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("wake pulse too long");
  property p_irq_stop; wake_irq_o |-> mode_o == `STS_M_STOP; endproperty
  a_irq_stop: assert property (p_irq_stop) else $error("wake pulse outside Stop");
  property p_wd_irq; wd_long_window_start_o |-> wake_irq_o; endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("watchdog start without wake");
  property p_rx_rise; $rose(rx_low_o) |-> mode_o == `STS_M_STOP; endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("receive low outside Stop");
  property p_sec_ot; sec_tsd_i [*5] |-> !sec_reg_en_o; endproperty
  a_sec_ot: assert property (p_sec_ot) else $error("secondary on while hot");
  property p_xcvr_ot; xcvr_tsd_i [*5] |-> !xcvr_tx_en_o; endproperty
  a_xcvr_ot: assert property (p_xcvr_ot) else $error("transmitter on while hot");
  property p_por_loss;
    !vs_por_ok_i [*5] |-> !reset_out_n_o && !main_reg_en_o && mode_o == `STS_M_INIT;
  endproperty
  a_por_loss: assert property (p_por_loss) else $error("supply loss not reset");
  property p_main_uv; (main_below_rst_i && main_reg_en_o) [*5] |-> !reset_out_n_o; endproperty
  a_main_uv: assert property (p_main_uv) else $error("no reset on main low");
endmodule
bind sts_supervisor sts_supervisor_monitor u_mon (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .vs_por_ok_i(vs_por_ok_i), .main_below_rst_i(main_below_rst_i), .sec_tsd_i(sec_tsd_i),
  .xcvr_tsd_i(xcvr_tsd_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reset_out_n_o(reset_out_n_o), .main_reg_en_o(main_reg_en_o), .sec_reg_en_o(sec_reg_en_o),
  .xcvr_tx_en_o(xcvr_tx_en_o), .wake_irq_o(wake_irq_o), .rx_low_o(rx_low_o),
  .wd_long_window_start_o(wd_long_window_start_o), .mode_o(mode_o));
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the supply and thermal supervisor
`include "sts_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 50;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] mon = 16'h8001;
  wire [3:0] a;
  wire [15:0] wd;
  wire wr;
  wire rd;
  logic [15:0] rdata;
  logic [15:0] d;
  logic rst_n, fail, men, sen, txe, irq, rxl, wds;
  logic [1:0] xf;
  logic [2:0] mode;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'hecc9;
  int i, t;
  int src[6] = '{1, 2, 3, 11, 10, 8};
  int fb[6] = '{1, 2, 3, 11, 9, 8};
  always #2.5 core_clk_i = ~core_clk_i;
  sts_mcu_model mcu (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(a),
    .reg_wdata_o(wd), .reg_wr_o(wr), .reg_rd_o(rd));
  sts_supervisor #(.SC_CYCLES(SC), .BLANK_CYCLES(10)) dut (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .vs_por_ok_i(mon[0]), .battery_undervoltage_flag_i(mon[1]), .battery_overvoltage_flag_i(mon[2]),
    .main_warn_i(mon[3]), .main_below_rst_i(mon[4]), .main_below_rt1_i(mon[5]),
    .main_ov_i(mon[6]), .sec_uv_i(mon[7]), .xcvr_uv_i(mon[8]), .sec_tsd_i(mon[9]),
    .xcvr_tsd_i(mon[10]), .tpw_i(mon[11]), .bus_wake_i(mon[12]),
    .load_above_peak_i(mon[13]), .charge_pump_en_i(mon[14]),
    .config_strap_state_i(mon[15]), .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reset_out_n_o(rst_n), .fail_output_o(fail),
    .main_reg_en_o(men), .sec_reg_en_o(sen), .xcvr_tx_en_o(txe), .xcvr_fail_o(xf),
    .wake_irq_o(irq), .rx_low_o(rxl), .wd_long_window_start_o(wds), .mode_o(mode));
  task automatic conclude;
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well above the few reset delays the run needs
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] flag(input int b);
    return 16'h1 << b;
  endfunction
  // Sample one step past the edge so registered outputs have landed
  task automatic cyc_n(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    t = 0;
    while (mode !== m && t < lim) begin
      cyc_n(1);
      t++;
    end
  endtask
  task automatic st(input logic [15:0] exp);
    mcu.rd(`STS_REG_STATUS, d);
    chk_reg(d, exp);
  endtask
  initial begin
    cyc_n(4);
    srst_i <= 1'b0;
    t = 0;
    while (rst_n !== 1'b1 && t < 3000) begin
      cyc_n(1);
      t++;
    end
    chk_pin(t >= 2000, 1'b1);
    st(flag(`STS_F_POR));
    mcu.rd(`STS_REG_CTRL, d);
    chk_reg(d, {8'h00, `STS_CTRL_RST});
    mcu.wr(4'he, 16'($random(seed)));
    mcu.rd(4'hf, d);
    chk_reg(d, 16'h0);
    mcu.wr(`STS_REG_CLEAR, flag(`STS_F_POR));
    mcu.wr(`STS_REG_MODE_REQ, 16'(`STS_M_NORMAL));
    mcu.rd(`STS_REG_MODE, d);
    chk_reg(d, 16'(`STS_M_NORMAL));
    // Each monitor sets only its own flag; clears bounce while the cause stays
    for (i = 0; i < 6; i++) begin
      mon[src[i]] <= 1'b1;
      cyc_n(6 + ($random(seed) & 7));
      mcu.wr(`STS_REG_CLEAR, flag(fb[i]));
      st(flag(fb[i]));
      if (i == 4) chk_pin(txe, 1'b0);
      if (i == 4) chk_reg(16'(xf), 16'h1);
      mon[src[i]] <= 1'b0;
      cyc_n(4);
      mcu.wr(`STS_REG_CLEAR, flag(fb[i]));
      st(16'h0);
    end
    chk_pin(txe, 1'b1);
    // Bus wake in Stop, with and without the watchdog start enabled
    for (i = 1; i >= 0; i--) begin
      mcu.enter_stop(16'(i));
      mcu.wr(`STS_REG_CTRL, 16'(1 - i));
      mcu.rd(`STS_REG_CTRL, d);
      chk_reg(d & 16'h1, 16'(i));
      mon[12] <= 1'b1;
      t = 0;
      while (irq !== 1'b1 && t < 8) begin
        cyc_n(1);
        t++;
      end
      chk_pin(irq, 1'b1);
      chk_pin(wds, i[0]);
      chk_pin(rxl, 1'b1);
      mon[12] <= 1'b0;
      mcu.wr(`STS_REG_MODE_REQ, 16'(`STS_M_NORMAL));
      cyc_n(3);
      chk_pin(rxl, 1'b0);
    end
    // Main overvoltage with reset enabled and strap high: restart then back
    mcu.wr(`STS_REG_CTRL, 16'h0005);
    mon[6] <= 1'b1;
    wait_mode(`STS_M_RESTART, 10);
    chk_reg(16'(mode), 16'(`STS_M_RESTART));
    wait_mode(`STS_M_NORMAL, 3000);
    chk_pin(t >= 2000, 1'b1);
    chk_pin(fail, 1'b1);
    mcu.rd(`STS_REG_CTRL, d);
    chk_reg(d, 16'h0001);
    st(flag(`STS_F_MAIN_OV));
    mon[6] <= 1'b0;
    cyc_n(4);
    mcu.wr(`STS_REG_CLEAR, 16'h1fff);
    mcu.wr(`STS_REG_MODE_REQ, 16'(`STS_M_NORMAL));
    cyc_n(2);
    chk_pin(fail, 1'b0);
    // Secondary regulator: blanked start, undervoltage, then overtemperature
    mcu.wr(`STS_REG_CTRL, 16'h0011);
    cyc_n(20);
    chk_pin(sen, 1'b1);
    mon[7] <= 1'b1;
    cyc_n(6);
    st(flag(`STS_F_SEC_UV));
    mon[7] <= 1'b0;
    mon[9] <= 1'b1;
    cyc_n(6);
    chk_pin(sen, 1'b0);
    mcu.rd(`STS_REG_CTRL, d);
    chk_reg(d, 16'h0001);
    st(16'h0680);
    mon[9] <= 1'b0;
    cyc_n(4);
    mcu.wr(`STS_REG_CLEAR, 16'h1fff);
    st(16'h0);
    chk_pin(sen, 1'b0);
    // Long main dip under battery undervoltage must not count as a short
    mon[1] <= 1'b1;
    mon[4] <= 1'b1;
    cyc_n(3 * SC);
    chk_pin(rst_n, 1'b0);
    chk_reg(16'(mode), 16'(`STS_M_RESTART));
    mon[4] <= 1'b0;
    cyc_n(4);
    mon[1] <= 1'b0;
    wait_mode(`STS_M_NORMAL, 3000);
    st(flag(`STS_F_MAIN_UV) | flag(`STS_F_BATTERY_UNDERVOLTAGE_FLAG));
    mcu.wr(`STS_REG_CLEAR, 16'h1fff);
    // Same dip with healthy battery: short circuit to Fail-Safe
    mon[4] <= 1'b1;
    wait_mode(`STS_M_FAILSAFE, 4 * SC);
    chk_reg(16'(mode), 16'(`STS_M_FAILSAFE));
    chk_pin(men, 1'b0);
    chk_pin(fail, 1'b1);
    mcu.rd(`STS_REG_STATUS, d);
    chk_reg(d & 16'h1040, 16'h1040);
    // Supply loss resets everything into Init
    mon[0] <= 1'b0;
    cyc_n(6);
    chk_reg(16'(mode), 16'(`STS_M_INIT));
    chk_pin(rst_n, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
